// ---- core/twm_defines.svh ----
// Constants of the two-wire bus master: timing figures, field widths,
// bit positions and byte codes. Included by the package and the core.
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// ------------------------------------------------------------
// Timing figures in their own units
// ------------------------------------------------------------
`define TWM_CLK_NS 50
`define TWM_BIT_NS 2500
`define TWM_NS_PER_MS 1000000
`define TWM_TOUT_MS 25
`define TWM_MEXT_MS 10
`define TWM_SEXT_MS 25

// ------------------------------------------------------------
// Widths, bit positions and codes
// ------------------------------------------------------------
`define TWM_QW 8
`define TWM_TW 20
`define TWM_F_DONE 0
`define TWM_F_ANAK 1
`define TWM_F_DNAK 2
`define TWM_F_ARB 3
`define TWM_F_PEC 4
`define TWM_F_TOUT 5
`define TWM_NFLAG 6
`define TWM_TEN_HDR 5'h1e
`define TWM_GCALL 8'h00
`define TWM_CRC_POLY 8'h07
`define TWM_CRC_INIT 8'h00
`define TWM_RX_FILL 9'h1ff
`define TWM_MSB_BIT 4'h7
`define TWM_ACK_BIT 4'h8

`endif

// ---- core/twm_master.sv ----
// Two-wire bus master core: start/stop, byte engine, arbitration,
// SMBus packet checking and clock-low timeouts.
// Assumes open-drain pads with pull-ups outside; line inputs are asynchronous.
//
// Notes on behaviour
// - Master only; single or multi-byte transfers
// - Lost arbitration releases both lines itself
// - Bit rate set by quarter-bit parameter
// - Seven-bit, ten-bit and general call addressing
// - Repeated start supported; no start byte
// - SMBus CRC appended, checked, steers acknowledge
// - SMBus clock low timeout detected
// - Master cumulative clock stretch limit enforced
// - Slave cumulative clock stretch limit enforced
// - Optional two-way alert line
// - Up to 255 data bytes, zero data bytes allowed
// - Clock held low while buffers not ready
// - Lines only pulled low or released
// - Stopped clock simply freezes all state
// - No debug freeze input exists
// - Handshake ports for transmit and receive bytes
// - Interrupt output for enabled events
// - Bytes sent MSB first, then acknowledge slot
// - Start and stop made while clock high
`timescale 1ns/100ps
`include "twm_defines.svh"

module twm_master
  import twm_pkg::*;
#(
  parameter int QUARTER_CYC = `TWM_BIT_NS / 4 / `TWM_CLK_NS,
  parameter int TOUT_CYC = `TWM_TOUT_MS * (`TWM_NS_PER_MS / `TWM_CLK_NS),
  parameter int MEXT_CYC = `TWM_MEXT_MS * (`TWM_NS_PER_MS / `TWM_CLK_NS),
  parameter int SEXT_CYC = `TWM_SEXT_MS * (`TWM_NS_PER_MS / `TWM_CLK_NS)
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire twm_cmd_s cmd_i,
  output logic cmd_ready_o,
  input wire logic smbus_en_i,
  input wire logic stretch_en_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire twm_flags_t status_clear_i,
  input wire twm_flags_t irq_en_i,
  output twm_flags_t status_o,
  output logic irq_o,
  output logic bus_busy_o,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_n_o,
  input wire logic bus_alert_line_i,
  output logic bus_alert_line_o,
  output logic bus_alert_line_oe_n_o,
  input wire logic alert_drive_i,
  output logic alert_o
);

  // ------------------------------------------------------------
  // Constants and helpers
  // ------------------------------------------------------------
  localparam twm_qcnt_t QLD = twm_qcnt_t'(QUARTER_CYC - 1);
  localparam twm_tcnt_t TOUT_LIM = twm_tcnt_t'(TOUT_CYC);
  localparam twm_tcnt_t MEXT_LIM = twm_tcnt_t'(MEXT_CYC);
  localparam twm_tcnt_t SEXT_LIM = twm_tcnt_t'(SEXT_CYC);

  twm_state_s r;
  twm_state_s n;
  logic scl_in;
  logic sda_in;
  logic tick;
  logic listen;
  logic nak;
  logic pec_on;

  // CRC-8 over one byte
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      x = x[7] ? ({x[6:0], 1'b0} ^ `TWM_CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction

  // Address byte for each address phase
  function automatic logic [7:0] adr_byte(input twm_cmd_s c, input twm_ph_e p);
    logic [7:0] b;
    b = {c.addr[6:0], c.read};
    if (c.gcall)
    begin
      b = `TWM_GCALL;
    end
    else if (p == PH_ADR2)
    begin
      b = c.addr[7:0];
    end
    else if (c.ten)
    begin
      b = {`TWM_TEN_HDR, c.addr[9:8], p == PH_ADR3};
    end
    return b;
  endfunction

  // ------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------
  assign scl_in = r.scl_s[1];
  assign sda_in = r.sda_s[1];
  assign pec_on = r.cmd.pec && smbus_en_i && (r.cmd.nbytes != 8'h00);
  assign listen = r.cmd.read && (r.ph == PH_DATA || r.ph == PH_PEC);
  assign nak = (r.ph == PH_PEC) ? (r.crc != `TWM_CRC_INIT)
             : (r.left == 8'h01 && !pec_on);
  assign tick = (r.cnt == twm_qcnt_t'(0));
  // Bus busy and not owned, or a NAK or arbitration flag, holds off new commands
  assign cmd_ready_o = (r.st == S_IDLE) && (r.owned || !r.busy)
                     && !r.flags[`TWM_F_ANAK] && !r.flags[`TWM_F_DNAK]
                     && !r.flags[`TWM_F_ARB];
  assign tx_ready_o = (r.st == S_LOAD) && (r.ph == PH_DATA) && !r.cmd.read
                    && (r.left != 8'h00);
  assign rx_data_o = r.rx_data;
  assign rx_valid_o = r.rx_full;
  assign status_o = r.flags;
  assign irq_o = |(r.flags & irq_en_i);
  assign bus_busy_o = r.busy;
  // Open drain: value low, enable only while pulling
  assign serial_clock_line_o = 1'b0;
  assign serial_clock_line_oe_n_o = ~r.scl_drv;
  assign serial_data_line_o = 1'b0;
  assign serial_data_line_oe_n_o = ~r.sda_drv;
  assign bus_alert_line_o = 1'b0;
  assign bus_alert_line_oe_n_o = ~r.alert_drv;
  assign alert_o = ~r.alm_s[1];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    n = r;
    // Line synchronisers and bus watch
    n.scl_s = {r.scl_s[0], serial_clock_line_i};
    n.sda_s = {r.sda_s[0], serial_data_line_i};
    n.alm_s = {r.alm_s[0], bus_alert_line_i};
    n.scl_q = scl_in;
    n.sda_q = sda_in;
    if (scl_in && r.scl_q && r.sda_q && !sda_in)
    begin
      n.busy = 1'b1;
    end
    if (scl_in && r.scl_q && !r.sda_q && sda_in)
    begin
      n.busy = 1'b0;
    end
    n.alert_drv = alert_drive_i;
    // Clears first, so a same-cycle set wins
    if (rx_ready_i)
    begin
      n.rx_full = 1'b0;
    end
    n.flags = r.flags & ~status_clear_i;
    // Quarter-bit timer
    if (!tick)
    begin
      n.cnt = r.cnt - 1'b1;
    end
    // Clock-low watch for SMBus
    n.low_cnt = (smbus_en_i && !scl_in) ? r.low_cnt + 1'b1 : twm_tcnt_t'(0);
    if (r.st == S_IDLE && !r.owned)
    begin
      n.mext = twm_tcnt_t'(0);
      n.sext = twm_tcnt_t'(0);
    end
    // Released clock still low: slave stretch, hold the timer
    if (((r.st == S_BIT && r.q == 2'd2) || (r.st != S_BIT && r.st != S_LOAD
        && r.st != S_IDLE && r.q == 2'd1)) && !r.scl_drv && !scl_in)
    begin
      n.cnt = QLD;
      n.sext = r.sext + 1'b1;
    end

    case (r.st)
      S_IDLE:
      begin
        if (cmd_valid_i && cmd_ready_o)
        begin
          n.cmd = cmd_i;
          n.left = cmd_i.nbytes;
          n.q = 2'd0;
          n.cnt = QLD;
          if (r.owned && !cmd_i.start)
          begin
            n.st = S_LOAD;
            n.ph = PH_DATA;
          end
          else
          begin
            n.st = S_START;
            n.ph = PH_ADR1;
            n.crc = `TWM_CRC_INIT;
          end
        end
      end
      S_START:
      begin
        case (r.q)
          2'd0: n.sda_drv = 1'b0;
          2'd1: n.scl_drv = 1'b0;
          2'd2: n.sda_drv = 1'b1;
          default: n.scl_drv = 1'b1;
        endcase
        if (tick)
        begin
          n.q = r.q + 1'b1;
          n.cnt = QLD;
          if (r.q == 2'd3)
          begin
            n.owned = 1'b1;
            n.sh = {adr_byte(r.cmd, r.ph), 1'b1};
            n.crc = crc8(r.crc, adr_byte(r.cmd, r.ph));
            n.bitn = 4'h0;
            n.st = S_BIT;
          end
        end
      end
      S_LOAD:
      begin
        n.mext = r.mext + 1'b1;
        if (r.left == 8'h00 && r.ph == PH_DATA && pec_on)
        begin
          n.ph = PH_PEC;
        end
        else if (r.left == 8'h00 && r.ph == PH_DATA)
        begin
          n.flags[`TWM_F_DONE] = 1'b1;
          n.st = r.cmd.stop ? S_STOP : S_IDLE;
          n.q = 2'd0;
          n.cnt = QLD;
        end
        else if (r.cmd.read && (!r.rx_full || !stretch_en_i))
        begin
          n.sh = `TWM_RX_FILL;
          n.st = S_BIT;
          n.cnt = QLD;
        end
        else if (!r.cmd.read && r.ph == PH_PEC)
        begin
          n.sh = {r.crc, 1'b1};
          n.st = S_BIT;
          n.cnt = QLD;
        end
        else if (!r.cmd.read && tx_valid_i)
        begin
          n.sh = {tx_data_i, 1'b1};
          n.crc = crc8(r.crc, tx_data_i);
          n.st = S_BIT;
          n.cnt = QLD;
        end
      end
      S_BIT:
      begin
        case (r.q)
          2'd0:
          begin
            n.scl_drv = 1'b1;
            n.sda_drv = (r.bitn == `TWM_ACK_BIT) ? (listen && !nak)
                      : (!listen && !r.sh[8]);
          end
          2'd1: n.scl_drv = 1'b0;
          default: n.scl_drv = r.scl_drv;
        endcase
        if (tick && r.q != 2'd3)
        begin
          n.q = r.q + 1'b1;
          n.cnt = QLD;
        end
        else if (tick && !r.sda_drv && !sda_in && r.bitn != `TWM_ACK_BIT && !listen)
        begin
          n.scl_drv = 1'b0;
          n.sda_drv = 1'b0;
          n.st = S_IDLE;
          n.owned = 1'b0;
          n.flags[`TWM_F_ARB] = 1'b1;
        end
        else if (tick)
        begin
          n.scl_drv = 1'b1;
          n.q = 2'd0;
          n.cnt = QLD;
          n.sh = {r.sh[7:0], sda_in};
          n.bitn = r.bitn + 1'b1;
          if (r.bitn == `TWM_MSB_BIT && listen)
          begin
            n.crc = crc8(r.crc, {r.sh[6:0], sda_in});
          end
          if (r.bitn == `TWM_ACK_BIT)
          begin
            n.bitn = 4'h0;
            n.st = S_LOAD;
            if (r.ph == PH_ADR1 || r.ph == PH_ADR2 || r.ph == PH_ADR3)
            begin
              if (sda_in)
              begin
                n.flags[`TWM_F_ANAK] = 1'b1;
                n.st = S_STOP;
              end
              else if (r.ph == PH_ADR1 && r.cmd.ten && !r.cmd.gcall)
              begin
                n.ph = PH_ADR2;
                n.sh = {adr_byte(r.cmd, PH_ADR2), 1'b1};
                n.crc = crc8(r.crc, adr_byte(r.cmd, PH_ADR2));
                n.st = S_BIT;
              end
              else if (r.ph == PH_ADR2 && r.cmd.read)
              begin
                n.ph = PH_ADR3;
                n.st = S_START;
              end
              else
              begin
                n.ph = PH_DATA;
              end
            end
            else if (r.ph == PH_DATA && listen)
            begin
              n.rx_data = r.sh[7:0];
              n.rx_full = 1'b1;
              n.left = r.left - 1'b1;
            end
            else if (r.ph == PH_DATA && sda_in)
            begin
              n.flags[`TWM_F_DNAK] = 1'b1;
              n.st = S_STOP;
            end
            else if (r.ph == PH_DATA)
            begin
              n.left = r.left - 1'b1;
            end
            else
            begin
              n.flags[`TWM_F_PEC] = listen && (r.crc != `TWM_CRC_INIT);
              n.flags[`TWM_F_DONE] = 1'b1;
              n.st = r.cmd.stop ? S_STOP : S_IDLE;
            end
          end
        end
      end
      S_STOP:
      begin
        case (r.q)
          2'd0: n.sda_drv = 1'b1;
          2'd1: n.scl_drv = 1'b0;
          default: n.sda_drv = 1'b0;
        endcase
        if (tick)
        begin
          n.q = r.q + 1'b1;
          n.cnt = QLD;
          if (r.q == 2'd2)
          begin
            n.st = S_IDLE;
            n.owned = 1'b0;
            n.q = 2'd0;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase

    // SMBus limits: give up the bus
    if (smbus_en_i && (r.owned || r.st != S_IDLE) && (r.low_cnt >= TOUT_LIM
        || r.mext >= MEXT_LIM || r.sext >= SEXT_LIM))
    begin
      n.scl_drv = 1'b0;
      n.sda_drv = 1'b0;
      n.st = S_IDLE;
      n.owned = 1'b0;
      n.q = 2'd0;
      n.flags[`TWM_F_TOUT] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // A stopped clock just freezes this record
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// ---- core/twm_pkg.sv ----
// Types of the two-wire bus master: command, states and the state record.
// Assumes twm_defines.svh is on the include path.
package twm_pkg;
  `include "twm_defines.svh"

  typedef logic [`TWM_QW-1:0] twm_qcnt_t;
  typedef logic [`TWM_TW-1:0] twm_tcnt_t;
  typedef logic [`TWM_NFLAG-1:0] twm_flags_t;

  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_LOAD, S_STOP} twm_st_e;
  typedef enum logic [2:0] {PH_ADR1, PH_ADR2, PH_ADR3, PH_DATA, PH_PEC} twm_ph_e;

  // One transfer request
  typedef struct packed {
    logic start;
    logic stop;
    logic read;
    logic ten;
    logic gcall;
    logic pec;
    logic [7:0] nbytes;
    logic [9:0] addr;
  } twm_cmd_s;

  // Whole state of the core
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] alm_s;
    logic scl_q;
    logic sda_q;
    logic busy;
    logic owned;
    twm_st_e st;
    twm_ph_e ph;
    logic [1:0] q;
    twm_qcnt_t cnt;
    logic [3:0] bitn;
    logic [8:0] sh;
    twm_cmd_s cmd;
    logic [7:0] left;
    logic [7:0] crc;
    logic scl_drv;
    logic sda_drv;
    logic alert_drv;
    logic [7:0] rx_data;
    logic rx_full;
    twm_flags_t flags;
    twm_tcnt_t low_cnt;
    twm_tcnt_t mext;
    twm_tcnt_t sext;
  } twm_state_s;
endpackage

// ---- testbench/test_i2c_smbus_master.sv ----
// Bench of the two-wire bus master core with one target model.
// Assumes a 20 MHz clock and short timeout counts for simulation.
`timescale 1ns/100ps
`include "twm_defines.svh"
module test_i2c_smbus_master
  import twm_pkg::*;
;
  logic clk_i = 0, rstn_i = 0, cmd_valid_i = 0, smbus_en_i = 0, stretch_en_i = 1;
  logic tx_valid_i = 0, rx_ready_i = 0, alert_drive_i = 0, hold = 0, far_alert = 0;
  logic [7:0] tx_data_i = 8'h00, rx_data_o, s_adr, s_dat;
  twm_cmd_s cmd_i = '0;
  twm_flags_t status_clear_i = '0, irq_en_i = '0, status_o;
  logic cmd_ready_o, tx_ready_o, rx_valid_o, irq_o, bus_busy_o, alert_o, s_scl, s_sda;
  logic serial_clock_line_i, serial_clock_line_o, serial_clock_line_oe_n_o;
  logic serial_data_line_i, serial_data_line_o, serial_data_line_oe_n_o;
  logic bus_alert_line_i, bus_alert_line_o, bus_alert_line_oe_n_o;
  int num_errors = 0, cmp_count = 0, cyc = 0, s_wcnt, w;
  // Wired-AND lines with pull-ups
  assign serial_clock_line_i = serial_clock_line_oe_n_o & s_scl;
  assign serial_data_line_i = serial_data_line_oe_n_o & s_sda;
  assign bus_alert_line_i = bus_alert_line_oe_n_o & !far_alert;
  twm_master #(.QUARTER_CYC(2), .TOUT_CYC(150), .MEXT_CYC(100), .SEXT_CYC(300)) DUT (.*);
  twm_slave_model #(.ADDR(7'h2a)) u_far (.scl_i(serial_clock_line_i),
    .sda_i(serial_data_line_i), .hold_i(hold), .base_i(8'ha5), .scl_o(s_scl),
    .sda_o(s_sda), .adr_o(s_adr), .dat_o(s_dat), .wcnt_o(s_wcnt));
  always #25 clk_i = !clk_i;
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------
  // Helpers
  // ----------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function twm_cmd_s mk(input logic rd, ten, gc, pec, input logic [7:0] nb,
    input logic [9:0] ad);
    mk = '{1'b1, 1'b1, rd, ten, gc, pec, nb, ad};
  endfunction
  function logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  task send(input twm_cmd_s c);
    @(negedge clk_i);
    cmd_i = c;
    cmd_valid_i = 1;
    for (int n = 0; n < 300 && cmd_ready_o !== 1'b1; n++)
      @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 0;
  endtask
  task put_tx(input logic [7:0] d);
    tx_data_i = d;
    tx_valid_i = 1;
    for (int n = 0; n < 300 && tx_ready_o !== 1'b1; n++)
      @(negedge clk_i);
    @(negedge clk_i);
    tx_valid_i = 0;
  endtask
  task wait_flag(input int b);
    for (int n = 0; n < 3000 && status_o[b] !== 1'b1; n++)
      @(negedge clk_i);
  endtask
  task clr;
    @(negedge clk_i);
    status_clear_i = '1;
    @(negedge clk_i);
    status_clear_i = '0;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_write;
    w = s_wcnt;
    irq_en_i = 6'h01;
    send(mk(0, 0, 0, 0, 8'h01, 10'h02a));
    repeat (120) @(negedge clk_i);
    chk(serial_clock_line_i, 0);
    put_tx(8'h3c);
    wait_flag(`TWM_F_DONE);
    chk(s_adr, 8'h54);
    chk(s_dat, 8'h3c);
    chk(s_wcnt - w, 1);
    chk(irq_o, 1);
    repeat (16) @(negedge clk_i);
    chk(bus_busy_o, 0);
    clr;
    chk(irq_o, 0);
  endtask
  task t_zero;
    w = s_wcnt;
    send(mk(0, 0, 0, 0, 8'h00, 10'h02a));
    wait_flag(`TWM_F_DONE);
    chk(status_o, 6'h01);
    chk(s_wcnt - w, 0);
    clr;
  endtask
  task t_read;
    send(mk(1, 0, 0, 0, 8'h02, 10'h02a));
    for (int i = 0; i < 2; i++)
    begin
      for (int n = 0; n < 300 && rx_valid_o !== 1'b1; n++)
        @(negedge clk_i);
      repeat (40) @(negedge clk_i);
      chk(serial_clock_line_i, i);
      chk(rx_data_o, 8'ha5 + i);
      rx_ready_i = 1;
      @(negedge clk_i);
      rx_ready_i = 0;
    end
    wait_flag(`TWM_F_DONE);
    chk(s_adr, 8'h55);
    clr;
  endtask
  // Read with stretching off: bytes overwrite, clock never held
  task t_over;
    stretch_en_i = 0;
    send(mk(1, 0, 0, 0, 8'h02, 10'h02a));
    wait_flag(`TWM_F_DONE);
    chk(rx_data_o, 8'ha8);
    chk(rx_valid_o, 1);
    stretch_en_i = 1;
    rx_ready_i = 1;
    @(negedge clk_i);
    rx_ready_i = 0;
    clr;
  endtask
  task t_nak;
    twm_cmd_s c[3];
    logic [7:0] e[3];
    c = '{mk(0, 0, 0, 0, 8'h00, 10'h011), mk(0, 0, 1, 0, 8'h00, 10'h000),
      mk(0, 1, 0, 0, 8'h00, 10'h2a5)};
    e = '{8'h22, 8'h00, 8'hf4};
    for (int i = 0; i < 3; i++)
    begin
      send(c[i]);
      wait_flag(`TWM_F_ANAK);
      chk(s_adr, e[i]);
      chk(cmd_ready_o, 0);
      clr;
      repeat (16) @(negedge clk_i);
      chk(cmd_ready_o, 1);
    end
  endtask
  task t_alert;
    far_alert = 1;
    repeat (4) @(negedge clk_i);
    chk(alert_o, 1);
    far_alert = 0;
    alert_drive_i = 1;
    repeat (2) @(negedge clk_i);
    chk(bus_alert_line_i, 0);
    alert_drive_i = 0;
    repeat (4) @(negedge clk_i);
    chk(alert_o, 0);
  endtask
  task t_pec;
    smbus_en_i = 1;
    w = s_wcnt;
    send(mk(0, 0, 0, 1, 8'h01, 10'h02a));
    put_tx(8'h3c);
    wait_flag(`TWM_F_DONE);
    chk(s_wcnt - w, 2);
    chk(s_dat, crc8(crc8(8'h00, 8'h54), 8'h3c));
    chk(status_o, 6'h01);
    clr;
  endtask
  task t_mext;
    send(mk(0, 0, 0, 0, 8'h01, 10'h02a));
    wait_flag(`TWM_F_TOUT);
    repeat (4) @(negedge clk_i);
    chk(status_o[`TWM_F_TOUT], 1);
    chk(serial_clock_line_oe_n_o, 1);
    rstn_i = 0;
    repeat (8) @(negedge clk_i);
    rstn_i = 1;
  endtask
  task t_tout;
    send(mk(0, 0, 0, 0, 8'h01, 10'h02a));
    put_tx(8'h3c);
    hold = 1;
    wait_flag(`TWM_F_TOUT);
    repeat (20) @(negedge clk_i);
    chk(status_o[`TWM_F_TOUT], 1);
    chk(serial_data_line_oe_n_o, 1);
    hold = 0;
  endtask
  initial
  begin
    repeat (8) @(negedge clk_i);
    rstn_i = 1;
    @(negedge clk_i);
    t_write();
    t_zero();
    t_read();
    t_over();
    t_nak();
    t_alert();
    t_pec();
    t_mext();
    t_tout();
    tally_and_finish();
  end
endmodule

// ---- testbench/twm_master_sva.sv ----
// Port checker for the two-wire bus master core.
// Bound to every core instance; sees only the core's ports.
`timescale 1ns/100ps
`include "twm_defines.svh"
// ----------------
// Checker
// ----------------
module twm_master_sva
  import twm_pkg::*;
#(
  parameter int TOUT_CYC = 150
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cmd_ready_o,
  input wire logic smbus_en_i,
  input wire logic stretch_en_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire twm_flags_t status_clear_i,
  input wire twm_flags_t irq_en_i,
  input wire twm_flags_t status_o,
  input wire logic irq_o,
  input wire logic bus_busy_o,
  input wire logic serial_clock_line_i,
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_line_oe_n_o,
  input wire logic serial_data_line_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe_n_o,
  input wire logic bus_alert_line_oe_n_o,
  input wire logic alert_drive_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  int low_cyc;
  // Length of the current clock-low stretch
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      low_cyc <= 0;
    else if (serial_clock_line_i || !smbus_en_i)
      low_cyc <= 0;
    else if (low_cyc < TOUT_CYC + 8)
      low_cyc <= low_cyc + 1;
  end
  chk_lines_low: assert property (!serial_clock_line_o && !serial_data_line_o)
    else $error("line driven high");
  chk_start_high: assert property ($fell(serial_data_line_oe_n_o) && serial_clock_line_oe_n_o
    |-> serial_clock_line_i)
    else $error("data pulled low with clock line low");
  chk_irq_gate: assert property (irq_o == |(status_o & irq_en_i))
    else $error("interrupt output wrong");
  chk_flag_sticky: assert property (1 |=> ($past(status_o) & ~$past(status_clear_i)
    & ~status_o) == '0)
    else $error("flag lost without clear");
  chk_ready_refused: assert property (status_o[`TWM_F_ANAK] || status_o[`TWM_F_DNAK]
    || status_o[`TWM_F_ARB] |-> !cmd_ready_o)
    else $error("command accepted after error");
  chk_busy_on_start: assert property ($fell(serial_data_line_i) && serial_clock_line_i
    |-> ##[1:4] bus_busy_o)
    else $error("start not marked busy");
  chk_tx_stretch: assert property (tx_ready_o && !tx_valid_i
    |-> !serial_clock_line_oe_n_o)
    else $error("clock not held while awaiting byte");
  chk_rx_stands: assert property (stretch_en_i && rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte not held");
  chk_timeout_flag: assert property (low_cyc == TOUT_CYC + 8
    |-> status_o[`TWM_F_TOUT])
    else $error("clock low timeout missed");
  chk_alert_follow: assert property (1 |=> bus_alert_line_oe_n_o == !$past(alert_drive_i))
    else $error("alert drive wrong");
  cov_rx_wait: cover property (rx_valid_o && !rx_ready_i);
  cov_tout: cover property ($rose(status_o[`TWM_F_TOUT]));
  cov_busy: cover property ($rose(bus_busy_o));
endmodule

bind twm_master twm_master_sva #(.TOUT_CYC(TOUT_CYC)) u_sva (.*);

// ---- testbench/twm_slave_model.sv ----
// Far-side model: one target device on the two-wire bus.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/100ps
// ----------------
// Target model
// ----------------
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
)
(
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic hold_i,
  input wire logic [7:0] base_i,
  output logic scl_o,
  output logic sda_o,
  output logic [7:0] adr_o,
  output logic [7:0] dat_o,
  output int wcnt_o
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rb = 8'h00;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  int bitc = 0;
  int rcnt = 0;
  initial sda_o = 1'b1;
  initial wcnt_o = 0;
  // Clock stretch: pull low or release only
  assign scl_o = !hold_i;
  // Start seen while clock high
  always @(negedge sda_i)
    if (scl_i)
    begin
      bitc = 0;
      first = 1'b1;
      sel = 1'b0;
    end
  // Bit capture, then acknowledge slot
  always @(posedge scl_i)
  begin
    if (bitc < 8)
      sh = {sh[6:0], sda_i};
    else
      go = !sda_i;
    bitc++;
  end
  // Drive acknowledge or read data while clock low
  always @(negedge scl_i)
  begin
    sda_o = 1'b1;
    if (bitc == 8)
    begin
      if (first)
      begin
        adr_o = sh;
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      else if (sel && !rd)
      begin
        dat_o = sh;
        wcnt_o++;
      end
      if (sel && (first || !rd))
        sda_o = 1'b0;
      first = 1'b0;
    end
    else
    begin
      if (bitc == 9)
        bitc = 0;
      if (sel && rd && go)
      begin
        if (bitc == 0)
          rb = base_i + rcnt[7:0];
        if (bitc == 0)
          rcnt++;
        sda_o = rb[7 - bitc];
      end
    end
  end
endmodule
